// ---- shared/uef_pkg.sv ----
package uef_pkg;
  localparam int NUM_EP = 4;
  localparam int REG_W = 8;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_EP_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_USB_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 4'h3;
  localparam int CTRL_SUSPEND_BIT = 0;
  localparam int CTRL_WAKEUP_BIT = 1;
  localparam int CTRL_BUSRST_BIT = 2;
  localparam int CTRL_RESUME_BIT = 3;
  localparam int CTRL_CLKEN_BIT = 4;
  localparam int CTRL_SUSPEND_CURRENT_REDUCTION_BIT = 5;
  localparam int EVT_EP_BIT = 0;
  localparam int EVT_BUSRST_BIT = 1;
  localparam int EVT_SUSPEND_BIT = 2;
  localparam int EVT_RESUME_BIT = 3;
  localparam int NUM_EVT = 4;
  localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
  localparam logic [NUM_EVT-1:0] MASK_RESET = 4'h0;
  typedef enum logic [1:0] {
    UEF_WK_IDLE = 2'b01,
    UEF_WK_SENT = 2'b10
  } uef_wake_state_t;
endpackage : uef_pkg

// ---- core/uef_sync.sv ----
`timescale 1ns/1ps
module uef_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule : uef_sync

// ---- core/uef_top.sv ----
`timescale 1ns/1ps
// Function
// [R1] a host access to an endpoint sets that endpoint's access flag.
// [R2] a flag raises the interrupt only when usb interrupts are enabled and the stack is not full.
// [R3] software clears an access flag by writing zero; hardware never clears it.
// [R4] the endpoint access status register holds endpoint n's flag at bit n, one meaning accessed.
// [R5] bits seven to four of the endpoint access status register read as zero.
// [R6] a detected bus reset sets the bus reset flag and raises an interrupt.
// [R7] writing one to the remote wakeup command starts wakeup signalling, zero does nothing.
// [R8] software holds the remote wakeup command high for at least one usb clock.
// [R9] the read only suspend flag follows bus suspend and raises an interrupt on entry.
// [R10] a resume event sets the read only resume flag with an interrupt, cleared on suspend exit.
module uef_top
  import uef_pkg::*;
#(
  parameter int N_EP = uef_pkg::NUM_EP
) (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic [uef_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [uef_pkg::REG_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [uef_pkg::REG_W-1:0] RDATA_O,
  input wire logic [N_EP-1:0] EP_ACCESS_I,
  input wire logic BUS_RESET_I,
  input wire logic BUS_SUSPEND_I,
  input wire logic BUS_RESUME_I,
  input wire logic USB_INT_EN_I,
  input wire logic STACK_FULL_I,
  output logic WAKEUP_REQ_O,
  output logic USB_CLK_EN_O,
  output logic SUSP_REDUCE_O,
  output logic IRQ_O
);
  import uef_pkg::*;

  logic [N_EP-1:0] ep_acc_s;
  logic bus_rst_s, susp_s, res_s;
  uef_sync #(.WIDTH(N_EP + 3)) u_sync (
    .clk_i(SYS_CLK_I),
    .nrst_i(NRST_I),
    .d_i({EP_ACCESS_I, BUS_RESET_I, BUS_SUSPEND_I, BUS_RESUME_I}),
    .q_o({ep_acc_s, bus_rst_s, susp_s, res_s})
  );

  logic [N_EP-1:0] ep_prev_q, ep_prev_d;
  logic rst_prev_q, rst_prev_d, susp_prev_q, susp_prev_d, res_prev_q, res_prev_d;
  logic [N_EP-1:0] ep_flag_q, ep_flag_d;
  logic busrst_q, busrst_d, susp_q, susp_d, resume_q, resume_d;
  logic wake_cmd_q, wake_cmd_d, clken_q, clken_d, suspend_current_reduction_q, suspend_current_reduction_d;
  logic [NUM_EVT-1:0] ist_q, ist_d, mask_q, mask_d;
  logic [REG_W-1:0] rdata_q, rdata_d;
  uef_wake_state_t wk_q, wk_d;
  logic wake_pulse_q, wake_pulse_d;
  logic ep_rise, rst_rise, susp_rise, susp_fall, res_rise;
  logic wr_ep, wr_ctrl, wr_mask, rd_ist;
  logic [NUM_EVT-1:0] evt;

  always_comb begin
    ep_prev_d = ep_acc_s;
    rst_prev_d = bus_rst_s;
    susp_prev_d = susp_s;
    res_prev_d = res_s;
    ep_rise = |(ep_acc_s & ~ep_prev_q);
    rst_rise = bus_rst_s & ~rst_prev_q;
    susp_rise = susp_s & ~susp_prev_q;
    susp_fall = ~susp_s & susp_prev_q;
    res_rise = res_s & ~res_prev_q;
    wr_ep = WR_I && (ADDR_I == ADDR_EP_STATUS);
    wr_ctrl = WR_I && (ADDR_I == ADDR_USB_CTRL);
    wr_mask = WR_I && (ADDR_I == ADDR_INT_MASK);
    rd_ist = RD_I && (ADDR_I == ADDR_INT_STATUS);
    // flags: software write first, new host access wins
    ep_flag_d = ep_flag_q;
    if (wr_ep) begin
      ep_flag_d = ep_flag_q & WDATA_I[N_EP-1:0]; // R3
    end
    ep_flag_d = ep_flag_d | (ep_acc_s & ~ep_prev_q); // R1 R4
    busrst_d = busrst_q;
    if (wr_ctrl && !WDATA_I[CTRL_BUSRST_BIT]) begin
      busrst_d = 1'b0;
    end
    if (rst_rise) begin
      busrst_d = 1'b1; // R6
    end
    susp_d = susp_s; // R9
    resume_d = resume_q;
    if (susp_fall) begin
      resume_d = 1'b0; // R10
    end
    if (res_rise) begin
      resume_d = 1'b1; // R10
    end
    wake_cmd_d = wake_cmd_q;
    clken_d = clken_q;
    suspend_current_reduction_d = suspend_current_reduction_q;
    if (wr_ctrl) begin
      wake_cmd_d = WDATA_I[CTRL_WAKEUP_BIT]; // R7
      clken_d = WDATA_I[CTRL_CLKEN_BIT];
      suspend_current_reduction_d = WDATA_I[CTRL_SUSPEND_CURRENT_REDUCTION_BIT];
    end
    // one wakeup request per rising command
    wk_d = wk_q;
    wake_pulse_d = 1'b0;
    case (wk_q)
      UEF_WK_IDLE: begin
        if (wake_cmd_q) begin
          wake_pulse_d = 1'b1; // R7 R8
          wk_d = UEF_WK_SENT;
        end
      end
      UEF_WK_SENT: begin
        if (!wake_cmd_q) begin
          wk_d = UEF_WK_IDLE;
        end
      end
      default: wk_d = UEF_WK_IDLE;
    endcase
    evt = '0;
    evt[EVT_EP_BIT] = ep_rise && USB_INT_EN_I && !STACK_FULL_I; // R2
    evt[EVT_BUSRST_BIT] = rst_rise; // R6
    evt[EVT_SUSPEND_BIT] = susp_rise; // R9
    evt[EVT_RESUME_BIT] = res_rise; // R10
    ist_d = (rd_ist ? '0 : ist_q) | evt;
    mask_d = wr_mask ? WDATA_I[NUM_EVT-1:0] : mask_q;
    rdata_d = REG_ZERO;
    if (RD_I) begin
      case (ADDR_I)
        ADDR_EP_STATUS: rdata_d[N_EP-1:0] = ep_flag_q; // R4 R5
        ADDR_USB_CTRL: begin
          rdata_d[CTRL_SUSPEND_BIT] = susp_q;
          rdata_d[CTRL_WAKEUP_BIT] = wake_cmd_q;
          rdata_d[CTRL_BUSRST_BIT] = busrst_q;
          rdata_d[CTRL_RESUME_BIT] = resume_q;
          rdata_d[CTRL_CLKEN_BIT] = clken_q;
          rdata_d[CTRL_SUSPEND_CURRENT_REDUCTION_BIT] = suspend_current_reduction_q;
        end
        ADDR_INT_STATUS: rdata_d[NUM_EVT-1:0] = ist_q;
        ADDR_INT_MASK: rdata_d[NUM_EVT-1:0] = mask_q;
        default: rdata_d = REG_ZERO;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ep_prev_q <= '0;
      rst_prev_q <= 1'b0;
      susp_prev_q <= 1'b0;
      res_prev_q <= 1'b0;
      ep_flag_q <= '0;
      busrst_q <= 1'b0;
      susp_q <= 1'b0;
      resume_q <= 1'b0;
      wake_cmd_q <= 1'b0;
      clken_q <= 1'b0;
      suspend_current_reduction_q <= 1'b0;
      wk_q <= UEF_WK_IDLE;
      wake_pulse_q <= 1'b0;
      ist_q <= '0;
      mask_q <= MASK_RESET;
      rdata_q <= REG_ZERO;
    end else begin
      ep_prev_q <= ep_prev_d;
      rst_prev_q <= rst_prev_d;
      susp_prev_q <= susp_prev_d;
      res_prev_q <= res_prev_d;
      ep_flag_q <= ep_flag_d;
      busrst_q <= busrst_d;
      susp_q <= susp_d;
      resume_q <= resume_d;
      wake_cmd_q <= wake_cmd_d;
      clken_q <= clken_d;
      suspend_current_reduction_q <= suspend_current_reduction_d;
      wk_q <= wk_d;
      wake_pulse_q <= wake_pulse_d;
      ist_q <= ist_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign RDATA_O = rdata_q;
  assign WAKEUP_REQ_O = wake_pulse_q;
  assign USB_CLK_EN_O = clken_q;
  assign SUSP_REDUCE_O = suspend_current_reduction_q;
  assign IRQ_O = |(ist_q & mask_q);

  a_ep_flag_set: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R1
    (ep_acc_s[0] && !ep_prev_q[0]) |=> ep_flag_q[0])
    else $error("endpoint flag not set on access");
  a_ep_flag_hold: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R3
    (ep_flag_q[0] && !wr_ep) |=> ep_flag_q[0])
    else $error("endpoint flag dropped without write");
  a_ep_int_gate: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R2
    (ep_rise && STACK_FULL_I && !ist_q[EVT_EP_BIT] && !rd_ist) |=> !ist_q[EVT_EP_BIT])
    else $error("endpoint interrupt while stack full");
  a_ep_upper_zero: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R5
    (RD_I && ADDR_I == ADDR_EP_STATUS) |=> RDATA_O[REG_W-1:N_EP] == '0)
    else $error("upper endpoint bits not zero");
  a_ep_read_bits: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R4
    (RD_I && ADDR_I == ADDR_EP_STATUS) |=> RDATA_O[N_EP-1:0] == $past(ep_flag_q))
    else $error("endpoint readback mismatch");
  a_busrst_evt: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R6
    rst_rise |=> (busrst_q && ist_q[EVT_BUSRST_BIT]))
    else $error("bus reset not flagged");
  a_wake_start: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R7
    (wr_ctrl && WDATA_I[CTRL_WAKEUP_BIT] && !wake_cmd_q && wk_q == UEF_WK_IDLE) |=> ##1 WAKEUP_REQ_O)
    else $error("wakeup not issued");
  a_wake_single: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R7
    WAKEUP_REQ_O |=> !WAKEUP_REQ_O)
    else $error("wakeup pulse too long");
  a_susp_follow: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R9
    susp_rise |=> (susp_q && ist_q[EVT_SUSPEND_BIT]))
    else $error("suspend not flagged");
  a_resume_clear: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R10
    (susp_fall && !res_rise) |=> !resume_q)
    else $error("resume flag not cleared on suspend exit");
  c_ep_access: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) ep_rise ##1 IRQ_O);
  c_bus_reset: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) rst_rise);
  c_wakeup: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) WAKEUP_REQ_O);
  c_resume: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) res_rise ##[1:50] susp_fall);
endmodule : uef_top

// ---- sim/uef_host_model.sv ----
`timescale 1ns/1ps
module uef_host_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [2:0] kind_i,
  input wire logic [1:0] ep_i,
  output logic [3:0] ep_access_o,
  output logic bus_reset_o,
  output logic bus_suspend_o,
  output logic bus_resume_o
);
  logic [2:0] hold_q;
  initial begin
    hold_q = 3'h0;
    ep_access_o = 4'h0;
    {bus_reset_o, bus_suspend_o, bus_resume_o} = 3'h0;
  end
  // events are levels held four cycles, then released; suspend is held until kind 3 clears it
  always @(posedge clk_i) begin
    if (go_i) begin
      hold_q <= 3'h4;
      case (kind_i)
        3'h0: ep_access_o[ep_i] <= 1'b1;
        3'h1: bus_reset_o <= 1'b1;
        3'h2: bus_suspend_o <= 1'b1;
        3'h3: bus_suspend_o <= 1'b0;
        default: bus_resume_o <= 1'b1;
      endcase
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
      if (hold_q == 3'h1) begin
        ep_access_o <= 4'h0;
        bus_reset_o <= 1'b0;
        bus_resume_o <= 1'b0;
      end
    end
  end
endmodule : uef_host_model

// ---- sim/usb_sie_event_flags_tb.sv ----
`timescale 1ns/1ps
module usb_sie_event_flags_tb;
  import uef_pkg::*;
  logic SYS_CLK_I, NRST_I, WR_I, RD_I, USB_INT_EN_I, STACK_FULL_I, go;
  logic [ADDR_W-1:0] ADDR_I;
  logic [REG_W-1:0] WDATA_I, RDATA_O, r, w, acc;
  logic [3:0] EP_ACCESS_I;
  logic BUS_RESET_I, BUS_SUSPEND_I, BUS_RESUME_I, WAKEUP_REQ_O, USB_CLK_EN_O, SUSP_REDUCE_O, IRQ_O;
  logic [2:0] kind;
  logic [1:0] ep;
  int err_count = 0, checked = 0, wake_cnt = 0, c0;
  uef_top u_dut (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .EP_ACCESS_I(EP_ACCESS_I), .BUS_RESET_I(BUS_RESET_I),
    .BUS_SUSPEND_I(BUS_SUSPEND_I), .BUS_RESUME_I(BUS_RESUME_I), .USB_INT_EN_I(USB_INT_EN_I),
    .STACK_FULL_I(STACK_FULL_I), .WAKEUP_REQ_O(WAKEUP_REQ_O), .USB_CLK_EN_O(USB_CLK_EN_O),
    .SUSP_REDUCE_O(SUSP_REDUCE_O), .IRQ_O(IRQ_O));
  uef_host_model u_host (.clk_i(SYS_CLK_I), .go_i(go), .kind_i(kind), .ep_i(ep), .ep_access_o(EP_ACCESS_I),
    .bus_reset_o(BUS_RESET_I), .bus_suspend_o(BUS_SUSPEND_I), .bus_resume_o(BUS_RESUME_I));
  initial begin
    SYS_CLK_I = 1'b0;
    forever #2 SYS_CLK_I = ~SYS_CLK_I;
  end
  always @(posedge SYS_CLK_I) if (WAKEUP_REQ_O === 1'b1) wake_cnt++;
  function automatic logic [7:0] ep_gate(logic en, logic full);
    return (en && !full) ? 8'h01 : 8'h00;
  endfunction : ep_gate
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge SYS_CLK_I) {WR_I, ADDR_I, WDATA_I} <= {1'b1, a, d};
    @(posedge SYS_CLK_I) WR_I <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge SYS_CLK_I) {RD_I, ADDR_I} <= {1'b1, a};
    @(posedge SYS_CLK_I) RD_I <= 1'b0;
    #1 r = RDATA_O;
  endtask : rd
  task automatic ev(logic [2:0] k, logic [1:0] e);
    @(posedge SYS_CLK_I) {go, kind, ep} <= {1'b1, k, e};
    @(posedge SYS_CLK_I) go <= 1'b0;
    repeat (8) @(posedge SYS_CLK_I);
  endtask : ev
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #200000 err_count++;
    give_verdict();
  end
  initial begin
    {NRST_I, WR_I, RD_I, go, USB_INT_EN_I, STACK_FULL_I} = 6'h0;
    {ADDR_I, WDATA_I, kind, ep} = '0;
    acc = 8'h00;
    void'($urandom(32'h2ecccf15));
    repeat (4) @(posedge SYS_CLK_I);
    NRST_I <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0]);
      chk(r, 8'h00);
    end
    wr(4'h9, 8'hff);
    rd(4'h9);
    chk(r, 8'h00);
    for (int it = 0; it < 10; it++) begin
      ep = 2'(it < 4 ? it : $urandom % 4);
      @(posedge SYS_CLK_I) {USB_INT_EN_I, STACK_FULL_I} <= it == 0 ? 2'b10 : it == 1 ? 2'b11 : it == 2 ? 2'b00 : 2'($urandom);
      ev(3'h0, ep);
      acc = acc | (8'h01 << ep);
      chk({7'h0, IRQ_O}, 8'h00);
      rd(ADDR_INT_STATUS);
      chk(r, ep_gate(USB_INT_EN_I, STACK_FULL_I));
      rd(ADDR_EP_STATUS);
      chk(r, acc);
      if (it > 3) begin
        w = 8'($urandom);
        wr(ADDR_EP_STATUS, w);
        acc = acc & w & 8'h0f;
        rd(ADDR_EP_STATUS);
        chk(r, acc);
      end
    end
    wr(ADDR_INT_MASK, 8'h0f);
    {USB_INT_EN_I, STACK_FULL_I} <= 2'b10;
    ev(3'h0, 2'h3);
    chk({7'h0, IRQ_O}, 8'h01);
    ev(3'h1, 2'h0);
    rd(ADDR_USB_CTRL);
    chk(r & 8'h04, 8'h04);
    rd(ADDR_INT_STATUS);
    chk(r, 8'h03);
    chk({7'h0, IRQ_O}, 8'h00);
    wr(ADDR_USB_CTRL, 8'h00);
    rd(ADDR_USB_CTRL);
    chk(r, 8'h00);
    ev(3'h2, 2'h0);
    chk({7'h0, IRQ_O}, 8'h01);
    rd(ADDR_INT_STATUS);
    chk(r, 8'h04);
    ev(3'h4, 2'h0);
    rd(ADDR_USB_CTRL);
    chk(r & 8'h09, 8'h09);
    rd(ADDR_INT_STATUS);
    chk(r, 8'h08);
    ev(3'h3, 2'h0);
    rd(ADDR_USB_CTRL);
    chk(r & 8'h09, 8'h00);
    c0 = wake_cnt;
    wr(ADDR_USB_CTRL, 8'h02);
    wr(ADDR_USB_CTRL, 8'h02);
    repeat (4) @(posedge SYS_CLK_I);
    chk(8'(wake_cnt - c0), 8'h01);
    wr(ADDR_USB_CTRL, 8'h00);
    repeat (4) @(posedge SYS_CLK_I);
    chk(8'(wake_cnt - c0), 8'h01);
    wr(ADDR_USB_CTRL, 8'h02);
    repeat (4) @(posedge SYS_CLK_I);
    chk(8'(wake_cnt - c0), 8'h02);
    for (int i = 0; i < 4; i++) begin
      w = 8'($urandom) & 8'h30;
      wr(ADDR_USB_CTRL, w);
      rd(ADDR_USB_CTRL);
      chk(r & 8'h30, w);
      chk({6'h0, SUSP_REDUCE_O, USB_CLK_EN_O}, {6'h0, w[5:4]});
    end
    // mid-run reset must clear flags, controls and the interrupt
    ev(3'h0, 2'h2);
    chk({7'h0, IRQ_O}, 8'h01);
    NRST_I <= 1'b0;
    repeat (2) @(posedge SYS_CLK_I);
    NRST_I <= 1'b1;
    rd(ADDR_EP_STATUS);
    chk(r, 8'h00);
    chk({6'h0, SUSP_REDUCE_O, USB_CLK_EN_O}, 8'h00);
    chk({7'h0, IRQ_O}, 8'h00);
    give_verdict();
  end
endmodule : usb_sie_event_flags_tb
